// >>> core/wdtb_watchdog.sv
// Watchdog timer with AHB-Lite register access and timed change protection
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns

module wdtb_watchdog #(
  parameter int TOUT_BASE = wdtb_pkg::WDTB_TOUT_BASE
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   clk_en,
  input  wire wdtb_pkg::wdtb_ahb_req_t ahb_req,
  output wdtb_pkg::wdtb_ahb_rsp_t     ahb_rsp,
  input  wire logic                   osc_tick,
  input  wire logic                   restart_pulse,
  input  wire logic                   vector_ack,
  input  wire logic                   global_irq_enable,
  input  wire logic                   always_on_fuse,
  output logic                        irq_request,
  output logic                        wake_request,
  output logic                        wdt_reset_pulse
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  wdtb_pkg::wdtb_state_t st_q;
  wdtb_pkg::wdtb_state_t st_d;

  logic        fuse_prog;
  logic        eff_re;
  logic        eff_ie;
  logic        running;
  logic [3:0]  ps_code;
  logic [20:0] lim_full;
  logic [19:0] lim_m1;
  logic        timeout;
  logic        addr_take;
  logic        unlock_wr;
  logic [7:0]  wbyte;

  // ---------------------------------------------------------------
  // Effective mode
  // ---------------------------------------------------------------
  assign fuse_prog = ~always_on_fuse;
  assign eff_re    = fuse_prog | st_q.re | st_q.rst_flag;
  assign eff_ie    = ~fuse_prog & st_q.ie;
  assign running   = eff_re | eff_ie;

  // Reserved codes behave as the longest period
  assign ps_code  = (st_q.psel > wdtb_pkg::WDTB_PS_MAX) ? wdtb_pkg::WDTB_PS_MAX : st_q.psel;
  assign lim_full = 21'(TOUT_BASE) << ps_code;
  assign lim_m1   = 20'(lim_full - 21'h1);
  // A count left above a shortened limit times out on the next tick
  assign timeout  = running & osc_tick & (st_q.count >= lim_m1);

  assign addr_take = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
  assign wbyte     = ahb_req.hwdata[7:0];
  assign unlock_wr = st_q.wr_ctrl & wbyte[wdtb_pkg::WDTB_CE_BIT] &
                     wbyte[wdtb_pkg::WDTB_RE_BIT];

  // ---------------------------------------------------------------
  // Register views
  // ---------------------------------------------------------------
  function automatic logic [7:0] ctrl_view(input wdtb_pkg::wdtb_state_t s, input logic fp);
    logic [7:0] v;
    v = 8'h00;
    v[wdtb_pkg::WDTB_FLAG_BIT] = s.flag;
    v[wdtb_pkg::WDTB_IE_BIT]   = ~fp & s.ie;
    v[wdtb_pkg::WDTB_PS3_BIT]  = s.psel[3];
    v[wdtb_pkg::WDTB_CE_BIT]   = s.chg_en;
    v[wdtb_pkg::WDTB_RE_BIT]   = fp | s.re | s.rst_flag;
    v[wdtb_pkg::WDTB_PSLO_MSB:0] = s.psel[2:0];
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d           = st_q;
    st_d.rst_pulse = 1'b0;

    // Change window countdown
    if (st_q.chg_en) begin
      if (st_q.chg_cnt == 3'h1) begin
        st_d.chg_en = 1'b0;
      end
      st_d.chg_cnt = st_q.chg_cnt - 3'h1;
    end

    // Data phase of a control write
    if (st_q.wr_ctrl) begin
      if (wbyte[wdtb_pkg::WDTB_FLAG_BIT]) begin
        st_d.flag = 1'b0;
      end
      st_d.ie = wbyte[wdtb_pkg::WDTB_IE_BIT];
      if (wbyte[wdtb_pkg::WDTB_RE_BIT]) begin
        st_d.re = 1'b1;
      end else if (st_q.chg_en && !st_q.rst_flag) begin
        st_d.re = 1'b0;
      end
      if (st_q.chg_en) begin
        st_d.psel = {wbyte[wdtb_pkg::WDTB_PS3_BIT], wbyte[wdtb_pkg::WDTB_PSLO_MSB:0]};
      end
      if (unlock_wr) begin
        st_d.chg_en  = 1'b1;
        st_d.chg_cnt = wdtb_pkg::WDTB_CHG_WIN_CYC;
      end
    end

    // Data phase of a reset cause write; writing zero clears the flag
    if (st_q.wr_cause && !wbyte[wdtb_pkg::WDTB_RFLAG_BIT]) begin
      st_d.rst_flag = 1'b0;
    end

    // Vectoring clears flag, and enable in combined mode
    if (vector_ack) begin
      st_d.flag = 1'b0;
      if (eff_re) begin
        st_d.ie = 1'b0;
      end
    end

    // Counter
    if (!running || restart_pulse || timeout) begin
      st_d.count = 20'h0;
    end else if (osc_tick) begin
      st_d.count = st_q.count + 20'h1;
    end

    // Time-out action; a set wins over any clear above
    if (timeout) begin
      if (eff_ie && !eff_re) begin
        st_d.flag = 1'b1;
      end else if (eff_ie && eff_re && !st_q.flag) begin
        st_d.flag = 1'b1;
      end else begin
        st_d.rst_pulse = 1'b1;
      end
    end

    // Watchdog reset reinitialises the control fields other than re, which keeps its value
    if (st_d.rst_pulse) begin
      st_d.rst_flag = 1'b1;
      st_d.flag     = 1'b0;
      st_d.ie       = 1'b0;
      st_d.psel     = 4'h0;
      st_d.chg_en   = 1'b0;
      st_d.chg_cnt  = 3'h0;
      st_d.count    = 20'h0;
    end

    // Address phase capture
    st_d.wr_ctrl  = addr_take & ahb_req.hwrite & (ahb_req.haddr == wdtb_pkg::WDTB_CTRL_OFF);
    st_d.wr_cause = addr_take & ahb_req.hwrite & (ahb_req.haddr == wdtb_pkg::WDTB_CAUSE_OFF);
    st_d.rdata    = 32'h0;
    if (addr_take && !ahb_req.hwrite) begin
      if (ahb_req.haddr == wdtb_pkg::WDTB_CTRL_OFF) begin
        st_d.rdata = {24'h0, ctrl_view(st_d, fuse_prog)};
      end else if (ahb_req.haddr == wdtb_pkg::WDTB_CAUSE_OFF) begin
        st_d.rdata = {28'h0, st_d.rst_flag, 3'h0};
      end
    end

    if (!clk_en) begin
      st_d = st_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= wdtb_pkg::WDTB_STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign ahb_rsp.hrdata    = st_q.rdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp     = 1'b0;
  assign wake_request      = st_q.flag & eff_ie;
  assign irq_request       = wake_request & global_irq_enable;
  assign wdt_reset_pulse   = st_q.rst_pulse;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_reset_pulse_width: assert property (@(posedge hclk) disable iff (!hresetn)
    (wdt_reset_pulse && clk_en) |=> !wdt_reset_pulse)
    else $error("watchdog reset pulse longer than one cycle");

  chk_change_auto_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(st_q.chg_en) ##0 (clk_en && !unlock_wr)[*4]) |=> !st_q.chg_en)
    else $error("change enable not cleared after four cycles");

  chk_fuse_lock: assert property (@(posedge hclk) disable iff (!hresetn)
    !always_on_fuse |-> (eff_re && !eff_ie && !irq_request))
    else $error("fuse does not force reset mode");

  chk_flag_forces_re: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q.rst_flag |-> ctrl_view(st_q, fuse_prog)[wdtb_pkg::WDTB_RE_BIT])
    else $error("reset enable reads clear while reset flag set");

  chk_irq_mode_tout: assert property (@(posedge hclk) disable iff (!hresetn)
    (timeout && clk_en && eff_ie && !eff_re) |=> (st_q.flag && !wdt_reset_pulse))
    else $error("interrupt mode time-out did not set flag");

  chk_reset_mode_tout: assert property (@(posedge hclk) disable iff (!hresetn)
    (timeout && clk_en && eff_re && !eff_ie) |=> wdt_reset_pulse)
    else $error("reset mode time-out gave no reset");

  chk_combined_first: assert property (@(posedge hclk) disable iff (!hresetn)
    (timeout && clk_en && eff_re && eff_ie && !st_q.flag) |=> (st_q.flag && !wdt_reset_pulse))
    else $error("first combined time-out wrong");

  chk_combined_second: assert property (@(posedge hclk) disable iff (!hresetn)
    (timeout && clk_en && eff_re && eff_ie && st_q.flag) |=> wdt_reset_pulse)
    else $error("second combined time-out gave no reset");

  chk_restart_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    (restart_pulse && clk_en) |=> (st_q.count == 20'h0))
    else $error("restart did not clear counter");

  chk_protected_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.wr_ctrl && !st_q.chg_en && clk_en && !timeout) |=> $stable(st_q.psel))
    else $error("prescaler changed without unlock");

  chk_vector_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (vector_ack && clk_en && !timeout) |=> !st_q.flag)
    else $error("vectoring did not clear flag");

  chk_reset_sets_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(wdt_reset_pulse) |-> st_q.rst_flag ##1 st_q.rst_flag)
    else $error("watchdog reset did not set reset flag");

  chk_stopped_count: assert property (@(posedge hclk) disable iff (!hresetn)
    (!running && clk_en) |=> (st_q.count == 20'h0))
    else $error("stopped watchdog counter not held at zero");

  chk_count_advance: assert property (@(posedge hclk) disable iff (!hresetn)
    (running && osc_tick && clk_en && !restart_pulse && !timeout) |=>
      (st_q.count == $past(st_q.count) + 20'h1))
    else $error("counter did not advance on oscillator tick");

  chk_count_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (running && !osc_tick && !restart_pulse && clk_en) |=> $stable(st_q.count))
    else $error("counter moved without oscillator tick");

  chk_freeze_state: assert property (@(posedge hclk) disable iff (!hresetn)
    !clk_en |=> $stable(st_q))
    else $error("state changed while clock enable low");

  chk_shortest_limit: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.psel == 4'h0) |-> (lim_full == 21'(TOUT_BASE)))
    else $error("shortest period wrong");

  chk_reserved_code: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.psel > wdtb_pkg::WDTB_PS_MAX) |-> (lim_full == 21'(TOUT_BASE * 512)))
    else $error("reserved prescaler code not longest period");

  chk_fuse_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
    !always_on_fuse |-> (ctrl_view(st_q, fuse_prog)[wdtb_pkg::WDTB_RE_BIT] &&
      !ctrl_view(st_q, fuse_prog)[wdtb_pkg::WDTB_IE_BIT]))
    else $error("fuse lock not visible in control view");

  chk_fuse_tout_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    (timeout && clk_en && !always_on_fuse) |=> wdt_reset_pulse)
    else $error("fuse mode time-out gave no reset");

  chk_pulse_only_tout: assert property (@(posedge hclk) disable iff (!hresetn)
    (!timeout && clk_en) |=> !wdt_reset_pulse)
    else $error("reset pulse without time-out");

  chk_flag_only_tout: assert property (@(posedge hclk) disable iff (!hresetn)
    (!st_q.flag && !timeout) |=> !st_q.flag)
    else $error("interrupt flag set without time-out");

  chk_write_one_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.wr_ctrl && wbyte[wdtb_pkg::WDTB_FLAG_BIT] && clk_en && !timeout) |=> !st_q.flag)
    else $error("writing one did not clear flag");

  chk_flag_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.flag && !(st_q.wr_ctrl && wbyte[wdtb_pkg::WDTB_FLAG_BIT]) && !vector_ack &&
      !timeout) |=> st_q.flag)
    else $error("interrupt flag lost without clear");

  chk_set_re_free: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.wr_ctrl && wbyte[wdtb_pkg::WDTB_RE_BIT] && clk_en) |=> st_q.re)
    else $error("setting reset enable refused");

  chk_re_protected: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.re && !st_q.chg_en) |=> st_q.re)
    else $error("reset enable cleared outside change window");

  chk_flag_blocks_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.re && st_q.rst_flag) |=> st_q.re)
    else $error("reset enable cleared while reset flag set");

  chk_unlock_opens: assert property (@(posedge hclk) disable iff (!hresetn)
    (unlock_wr && clk_en && !timeout) |=>
      (st_q.chg_en && (st_q.chg_cnt == wdtb_pkg::WDTB_CHG_WIN_CYC)))
    else $error("unlock write did not open change window");

  chk_cause_zero_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.wr_cause && !wbyte[wdtb_pkg::WDTB_RFLAG_BIT] && clk_en && !timeout) |=>
      !st_q.rst_flag)
    else $error("writing zero did not clear reset flag");

  chk_cause_holds: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.rst_flag && !st_q.wr_cause) |=> st_q.rst_flag)
    else $error("reset flag lost without write");

  chk_irq_gating: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_request |-> (ctrl_view(st_q, fuse_prog)[wdtb_pkg::WDTB_FLAG_BIT] &&
      ctrl_view(st_q, fuse_prog)[wdtb_pkg::WDTB_IE_BIT] && global_irq_enable))
    else $error("interrupt request without flag and enables");

  chk_wake_needs_ie: assert property (@(posedge hclk) disable iff (!hresetn)
    (st_q.flag && !fuse_prog && st_q.ie) |-> wake_request)
    else $error("no wake request on pending time-out");

  chk_vector_ie: assert property (@(posedge hclk) disable iff (!hresetn)
    (vector_ack && eff_re && clk_en) |=> !st_q.ie)
    else $error("vectoring did not clear interrupt enable");

  chk_rdata_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && !(addr_take && !ahb_req.hwrite)) |=> (ahb_rsp.hrdata == 32'h0))
    else $error("read data not zero outside a read");

endmodule

// >>> core/wdtb_pkg.sv
// Package: constants and carrier types for the watchdog timer block
package wdtb_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [31:0] WDTB_CTRL_OFF  = 32'h0000_0000;
  localparam logic [31:0] WDTB_CAUSE_OFF = 32'h0000_0004;

  // ---------------------------------------------------------------
  // Field positions, control/status register
  // ---------------------------------------------------------------
  localparam int WDTB_FLAG_BIT = 7;
  localparam int WDTB_IE_BIT   = 6;
  localparam int WDTB_PS3_BIT  = 5;
  localparam int WDTB_CE_BIT   = 4;
  localparam int WDTB_RE_BIT   = 3;
  localparam int WDTB_PSLO_MSB = 2;
  // Reset cause register
  localparam int WDTB_RFLAG_BIT = 3;

  // ---------------------------------------------------------------
  // Values after reset and counts
  // ---------------------------------------------------------------
  localparam logic [7:0]  WDTB_CTRL_RST     = 8'h00;
  localparam int          WDTB_OSC_KHZ      = 128;
  localparam int          WDTB_TOUT_BASE    = 2048;
  localparam logic [3:0]  WDTB_PS_MAX       = 4'h9;
  localparam logic [2:0]  WDTB_CHG_WIN_CYC  = 3'h4;
  localparam logic [1:0]  WDTB_HTRANS_NSEQ  = 2'h2;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } wdtb_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } wdtb_ahb_rsp_t;

  typedef struct packed {
    logic [19:0] count;
    logic        flag;
    logic        ie;
    logic        re;
    logic [3:0]  psel;
    logic        chg_en;
    logic [2:0]  chg_cnt;
    logic        rst_flag;
    logic        rst_pulse;
    logic        wr_ctrl;
    logic        wr_cause;
    logic [31:0] rdata;
  } wdtb_state_t;

  localparam wdtb_state_t WDTB_STATE_RST = '{default: '0};

endpackage

// >>> tb/wdtb_watchdog_tb.sv
// Self-checking testbench for the watchdog timer block
`timescale 1ns/1ns

module wdtb_watchdog_tb;
  localparam logic [31:0] CTRL  = wdtb_pkg::WDTB_CTRL_OFF;
  localparam logic [31:0] CAUSE = wdtb_pkg::WDTB_CAUSE_OFF;
  localparam int          LIMIT = 5000;

  logic                    hclk;
  logic                    hresetn;
  logic                    clk_en;
  wdtb_pkg::wdtb_ahb_req_t req;
  wdtb_pkg::wdtb_ahb_req_t ahb_in;
  wdtb_pkg::wdtb_ahb_rsp_t rsp;
  logic                    osc_tick;
  logic                    restart_pulse;
  logic                    vector_ack;
  logic                    global_irq_enable;
  logic                    always_on_fuse;
  logic                    irq_request;
  logic                    wake_request;
  logic                    wdt_reset_pulse;
  int                      n_fail;
  int                      checks_done;
  int                      n_rst;
  int                      cycles;

  // ---------------------------------------------------------------
  // Design and clock
  // ---------------------------------------------------------------
  wdtb_watchdog #(.TOUT_BASE(4)) dut (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .clk_en            (clk_en),
    .ahb_req           (ahb_in),
    .ahb_rsp           (rsp),
    .osc_tick          (osc_tick),
    .restart_pulse     (restart_pulse),
    .vector_ack        (vector_ack),
    .global_irq_enable (global_irq_enable),
    .always_on_fuse    (always_on_fuse),
    .irq_request       (irq_request),
    .wake_request      (wake_request),
    .wdt_reset_pulse   (wdt_reset_pulse)
  );

  always_comb begin
    ahb_in        = req;
    ahb_in.hready = rsp.hreadyout;
  end

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (wdt_reset_pulse === 1'b1) n_rst <= n_rst + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Single transfer: address phase, then data phase, each until hready
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    req.hsel   <= 1'b1;
    req.haddr  <= a;
    req.htrans <= wdtb_pkg::WDTB_HTRANS_NSEQ;
    req.hwrite <= w;
    req.hsize  <= 3'h2;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    req.hsel   <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= d;
    do @(posedge hclk); while (rsp.hreadyout !== 1'b1);
    r = rsp.hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0000_0000, r);
    chk(r, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      osc_tick <= 1'b1;
      @(posedge hclk);
      osc_tick <= 1'b0;
      @(posedge hclk);
    end
    @(posedge hclk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    req = '0;
    osc_tick = 1'b0;
    restart_pulse = 1'b0;
    vector_ack = 1'b0;
    global_irq_enable = 1'b1;
    always_on_fuse = 1'b1;
    n_fail = 0;
    checks_done = 0;
    n_rst = 0;
    cycles = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(CTRL, 32'h0000_0000);
    rd(CAUSE, 32'h0000_0000);
    rd(32'h0000_0008, 32'h0000_0000);
    wr(CTRL, 32'h0000_0040);
    tick(3);
    restart_pulse <= 1'b1;
    @(posedge hclk);
    restart_pulse <= 1'b0;
    tick(3);
    rd(CTRL, 32'h0000_0040);
    clk_en <= 1'b0;
    tick(2);
    clk_en <= 1'b1;
    rd(CTRL, 32'h0000_0040);
    tick(1);
    rd(CTRL, 32'h0000_00C0);
    chk({31'h0, irq_request}, 32'h0000_0001);
    chk({31'h0, wake_request}, 32'h0000_0001);
    global_irq_enable <= 1'b0;
    @(posedge hclk);
    chk({31'h0, irq_request}, 32'h0000_0000);
    global_irq_enable <= 1'b1;
    wr(CTRL, 32'h0000_00C0);
    rd(CTRL, 32'h0000_0040);
    wr(CTRL, 32'h0000_0000);
    tick(4);
    rd(CTRL, 32'h0000_0000);
    chk(n_rst, 32'h0000_0000);
    wr(CTRL, 32'h0000_0008);
    wr(CTRL, 32'h0000_0021);
    rd(CTRL, 32'h0000_0008);
    wr(CTRL, 32'h0000_0018);
    wr(CTRL, 32'h0000_0021);
    rd(CTRL, 32'h0000_0031);
    wr(CTRL, 32'h0000_0008);
    wr(CTRL, 32'h0000_0039);
    repeat (6) @(posedge hclk);
    wr(CTRL, 32'h0000_0000);
    rd(CTRL, 32'h0000_0029);
    restart_pulse <= 1'b1;
    @(posedge hclk);
    restart_pulse <= 1'b0;
    wr(CTRL, 32'h0000_0039);
    wr(CTRL, 32'h0000_0008);
    rd(CTRL, 32'h0000_0018);
    tick(4);
    chk(n_rst, 32'h0000_0001);
    rd(CAUSE, 32'h0000_0008);
    wr(CTRL, 32'h0000_0018);
    wr(CTRL, 32'h0000_0000);
    rd(CTRL, 32'h0000_0018);
    wr(CAUSE, 32'h0000_0000);
    rd(CAUSE, 32'h0000_0000);
    wr(CTRL, 32'h0000_0018);
    wr(CTRL, 32'h0000_0000);
    rd(CTRL, 32'h0000_0010);
    wr(CTRL, 32'h0000_0048);
    tick(4);
    rd(CTRL, 32'h0000_00C8);
    chk(n_rst, 32'h0000_0001);
    vector_ack <= 1'b1;
    @(posedge hclk);
    vector_ack <= 1'b0;
    rd(CTRL, 32'h0000_0008);
    wr(CTRL, 32'h0000_0048);
    tick(8);
    chk(n_rst, 32'h0000_0002);
    rd(CTRL, 32'h0000_0008);
    wr(CAUSE, 32'h0000_0000);
    wr(CTRL, 32'h0000_0018);
    wr(CTRL, 32'h0000_0000);
    always_on_fuse <= 1'b0;
    wr(CTRL, 32'h0000_0040);
    rd(CTRL, 32'h0000_0008);
    tick(4);
    chk(n_rst, 32'h0000_0003);
    close_out();
  end
endmodule
